// ==== include/sprs_consts.svh ====
// Constants for the setpoint program run/hold sequencer.
`ifndef SPRS_CONSTS_SVH
`define SPRS_CONSTS_SVH
// Register byte offsets.
`define SPRS_OFS_CTRL      8'h00
`define SPRS_OFS_STATUS    8'h04
`define SPRS_OFS_TIME      8'h08
`define SPRS_OFS_STARTSP   8'h0C
// Control field positions.
`define SPRS_CTRL_ENDSEG_LSB   0
`define SPRS_CTRL_CYCLES_LEFT_VIEW_LSB    8
`define SPRS_CTRL_ENDHOLD_BIT  16
`define SPRS_CTRL_LASTSP_BIT   17
`define SPRS_CTRL_DIFUNC_LSB   20
// Control reset values.
`define SPRS_RST_ENDSEG    4'hC
`define SPRS_RST_CYCLES_LEFT_VIEW     7'h00
`define SPRS_RST_ENDHOLD   1'h1
`define SPRS_RST_LASTSP    1'h1
`define SPRS_RST_DIFUNC    3'h0
// Segment and cycle limits.
`define SPRS_SEG_FIRST     4'h1
`define SPRS_SEG_LAST      4'hC
`define SPRS_CYC_MAX       7'h63
`define SPRS_MIN_PER_HOUR  6'h3B
// Digital input function codes.
`define SPRS_DI_NONE       3'h0
`define SPRS_DI_RUN        3'h1
`define SPRS_DI_HOLD       3'h2
`define SPRS_DI_RESTART    3'h3
`define SPRS_DI_BEGIN      3'h4
// Timing: clock rate, minute length, hold indicator blink half period.
`define SPRS_CLK_MHZ       250
`define SPRS_MINUTE_S      60
`define SPRS_BLINK_MS      500
`endif

// ==== include/sprs_pkg.sv ====
// Types for the setpoint program run/hold sequencer.
package sprs_pkg;
   // Program run state.
   typedef enum logic [1:0] {
      SPRS_HOLD,
      SPRS_RUN,
      SPRS_ENDED
   } sprs_state_t;

   // Whole register state of the sequencer.
   typedef struct packed {
      sprs_state_t st;
      sprs_state_t savedSt;
      logic        restorePend;
      logic        fresh;
      logic        done;
      logic        loadPend;
      logic        powerUp;
      logic [3:0]  seg;
      logic [6:0]  hh;
      logic [5:0]  mm;
      logic [6:0]  cyc;
      logic [33:0] tick;
      logic [31:0] blink;
      logic        blinkOn;
      logic        keyPrev;
      logic        diPrev;
      logic [15:0] startSp;
      logic [15:0] spOut;
      logic        spLoad;
      logic [1:0]  ctrlMode;
      logic        manual;
      logic [3:0]  cfgEndSeg;
      logic [6:0]  cfgRecyc;
      logic        cfgEndHold;
      logic        cfgLastSp;
      logic [2:0]  cfgDiFunc;
      logic        refused;
      logic        ack;
      logic [31:0] dat;
   } sprs_regs_t;
endpackage

// ==== verilog/sprs_sequencer.sv ====
// Run/hold sequencer for a ramp/soak setpoint program with a Wishbone slave.
`timescale 1ns/1ps
`include "sprs_consts.svh"

// Behaviour
// - Program parameter writes are accepted in hold or after the end, refused while running.
// - Run/hold key while held starts or resumes the program, running indicator on.
// - Run/hold key while running holds, shows hold indicator, freezes setpoint.
// - External hold contact closing while running forces hold, hold indicator blinks.
// - Keypad request wins over the external hold switch when they conflict.
// - Opening the external hold contact returns the program to running.
// - Report segment number 1 to 12, ramp or soak, and time left.
// - Keep and report remaining program cycles, 0 to 99.
// - After the final segment, hold or end programming as configured.
// - After the end, keep last setpoint or go manual with failsafe output.
// - At power-up after a lost program, hold at start, restore prior setpoint.
// - After power returns, enter the configured power-up control mode.
// - Run input closing places the program in run.
// - Hold input closing places the program in hold.
// - Restart input closing returns to first segment, run/hold mode unchanged.
// - Opening a run, hold or restart contact restores the prior state.
// - Begin input closing goes to first segment start in hold, cycles kept.
// - Opening the begin contact does nothing.
module sprs_sequencer
   import sprs_pkg::*;
#(
   parameter longint unsigned MINUTE_CYCLES =
      64'(`SPRS_MINUTE_S) * 64'(`SPRS_CLK_MHZ) * 64'd1000000,
   parameter longint unsigned BLINK_CYCLES =
      64'(`SPRS_BLINK_MS) * 64'(`SPRS_CLK_MHZ) * 64'd1000
) (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Wishbone classic slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Operator keypad and remote contact.
   input  wire logic        runHoldKey,
   input  wire logic        contactClosed,
   // Segment duration of the segment named by segNum.
   input  wire logic [6:0]  segHoursIn,
   input  wire logic [5:0]  segMinsIn,
   // Present setpoint and nonvolatile power-loss record.
   input  wire logic [15:0] setpointIn,
   input  wire logic        nvProgActive,
   input  wire logic [15:0] nvStartSp,
   input  wire logic [1:0]  powerOnModeIn,
   // Indicators.
   output logic             runIndicator,
   output logic             holdIndicator,
   output logic             spFreeze,
   output logic             paramEditOk,
   // Segment and cycle status.
   output logic      [3:0]  segNum,
   output logic             segIsRamp,
   output logic      [6:0]  timeHours,
   output logic      [5:0]  timeMins,
   output logic      [6:0]  cyclesLeft,
   // End and power-up actions.
   output logic             manualMode,
   output logic             failsafeOut,
   output logic      [1:0]  ctrlMode,
   output logic             progActive,
   output logic      [15:0] startSpOut,
   output logic      [15:0] spRestore,
   output logic             spRestoreLoad
);

   // ****************************************************************
   // State registers
   // ****************************************************************
   sprs_regs_t state_q;
   sprs_regs_t state_d;

   localparam logic [33:0] TICK_LAST  = 34'(MINUTE_CYCLES - 64'd1);
   localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 64'd1);

   // Requests decided this cycle, applied in one place below.
   logic keyEdge;
   logic closeEdge;
   logic openEdge;
   logic forcedHold;
   logic wbReq;
   logic writeCtrl;

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   // one-cycle requests
   assign keyEdge   = runHoldKey & ~state_q.keyPrev;
   assign closeEdge = contactClosed & ~state_q.diPrev;
   assign openEdge  = ~contactClosed & state_q.diPrev;
   assign wbReq     = wb_cyc_i & wb_stb_i & ~state_q.ack;
   assign writeCtrl = wbReq & wb_we_i & (wb_adr_i == `SPRS_OFS_CTRL);
   assign forcedHold = state_q.restorePend & contactClosed &
                       (state_q.cfgDiFunc == `SPRS_DI_HOLD) &
                       (state_q.st == SPRS_HOLD);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // All sequencing, bus decode and timing is decided here each cycle.
   always_comb begin
      logic goRun;
      logic goHold;
      logic goFirst;
      logic segEnd;
      goRun   = 1'b0;
      goHold  = 1'b0;
      goFirst = 1'b0;
      segEnd  = 1'b0;
      state_d = state_q;
      state_d.keyPrev = runHoldKey;
      state_d.diPrev  = contactClosed;
      state_d.spLoad  = 1'b0;

      if (state_q.powerUp) begin
         state_d.powerUp = 1'b0;
         state_d.ctrlMode = powerOnModeIn;
         if (nvProgActive) begin
            state_d.spOut   = nvStartSp;
            state_d.spLoad  = 1'b1;
            state_d.startSp = nvStartSp;
         end
      end

      if (keyEdge) begin
         state_d.restorePend = 1'b0;
         if (state_q.st == SPRS_RUN) begin
            goHold = 1'b1;
         end else begin
            goRun = 1'b1;
         end
      end else if (closeEdge) begin
         case (state_q.cfgDiFunc)
            `SPRS_DI_RUN: begin
               state_d.savedSt     = state_q.st;
               state_d.restorePend = 1'b1;
               goRun               = (state_q.st != SPRS_RUN);
            end
            `SPRS_DI_HOLD: begin
               if (state_q.st == SPRS_RUN) begin
                  state_d.savedSt     = state_q.st;
                  state_d.restorePend = 1'b1;
                  goHold              = 1'b1;
               end
            end
            `SPRS_DI_RESTART: begin
               state_d.savedSt     = state_q.st;
               state_d.restorePend = 1'b1;
               goFirst             = 1'b1;
            end
            `SPRS_DI_BEGIN: begin
               goFirst            = 1'b1;
               state_d.st         = SPRS_HOLD;
               state_d.done       = 1'b0;
               state_d.restorePend = 1'b0;
            end
            default: begin
               state_d.restorePend = 1'b0;
            end
         endcase
      end else if (openEdge && state_q.restorePend) begin
         // revert on open; begin never sets a pending restore
         state_d.restorePend = 1'b0;
         if (state_q.savedSt == SPRS_RUN) begin
            goRun = 1'b1;
         end else begin
            state_d.st = state_q.savedSt;
         end
      end

      // Apply hold request.
      if (goHold) begin
         state_d.st = SPRS_HOLD;
      end

      // Apply run request; a finished or fresh program starts over.
      if (goRun) begin
         state_d.st     = SPRS_RUN;
         state_d.manual = 1'b0;
         if (state_q.done || state_q.fresh) begin
            goFirst     = 1'b1;
            state_d.cyc = state_q.cfgRecyc;
            state_d.done = 1'b0;
         end
         if (state_q.fresh) begin
            state_d.startSp = setpointIn;
            state_d.fresh   = 1'b0;
         end
      end

      // Return to the first segment and reload its time.
      if (goFirst) begin
         state_d.seg      = `SPRS_SEG_FIRST;
         state_d.loadPend = 1'b1;
         state_d.tick     = '0;
      end else if (state_q.loadPend) begin
         // Duration inputs follow segNum one cycle later.
         state_d.loadPend = 1'b0;
         state_d.hh       = segHoursIn;
         state_d.mm       = segMinsIn;
      end else if (state_q.st == SPRS_RUN && !goHold) begin
         if (state_q.hh == 7'h00 && state_q.mm == 6'h00) begin
            segEnd = 1'b1;
         end else if (state_q.tick == TICK_LAST) begin
            state_d.tick = '0;
            if (state_q.mm != 6'h00) begin
               state_d.mm = state_q.mm - 6'h01;
            end else begin
               state_d.mm = `SPRS_MIN_PER_HOUR;
               state_d.hh = state_q.hh - 7'h01;
            end
         end else begin
            state_d.tick = state_q.tick + 34'h1;
         end
      end

      // Segment completion, recycle or program end.
      if (segEnd) begin
         state_d.tick = '0;
         if (state_q.seg < state_q.cfgEndSeg && state_q.seg < `SPRS_SEG_LAST) begin
            state_d.seg      = state_q.seg + 4'h1;
            state_d.loadPend = 1'b1;
         end else if (state_q.cyc != 7'h00) begin
            state_d.cyc      = state_q.cyc - 7'h01;
            state_d.seg      = `SPRS_SEG_FIRST;
            state_d.loadPend = 1'b1;
         end else begin
            state_d.done = 1'b1;
            state_d.st   = state_q.cfgEndHold ? SPRS_HOLD : SPRS_ENDED;
            state_d.manual      = ~state_q.cfgLastSp;
            state_d.restorePend = 1'b0;
         end
      end

      // Hold indicator blink timer runs only while the contact forces hold.
      if (forcedHold) begin
         if (state_q.blink == BLINK_LAST) begin
            state_d.blink   = '0;
            state_d.blinkOn = ~state_q.blinkOn;
         end else begin
            state_d.blink = state_q.blink + 32'h1;
         end
      end else begin
         state_d.blink   = '0;
         state_d.blinkOn = 1'b1;
      end

      // Wishbone: answer one cycle after the request, then drop.
      state_d.ack = wbReq;
      if (wbReq) begin
         state_d.dat = '0;
         if (wb_adr_i == `SPRS_OFS_CTRL) begin
            state_d.dat[`SPRS_CTRL_ENDSEG_LSB +: 4] = state_q.cfgEndSeg;
            state_d.dat[`SPRS_CTRL_CYCLES_LEFT_VIEW_LSB +: 7]  = state_q.cfgRecyc;
            state_d.dat[`SPRS_CTRL_ENDHOLD_BIT]     = state_q.cfgEndHold;
            state_d.dat[`SPRS_CTRL_LASTSP_BIT]      = state_q.cfgLastSp;
            state_d.dat[`SPRS_CTRL_DIFUNC_LSB +: 3] = state_q.cfgDiFunc;
         end else if (wb_adr_i == `SPRS_OFS_STATUS) begin
            state_d.dat[1:0]   = state_q.st;
            state_d.dat[7:4]   = state_q.seg;
            state_d.dat[8]     = state_q.seg[0];
            state_d.dat[9]     = state_q.manual;
            state_d.dat[22:16] = state_q.cyc;
            state_d.dat[24]    = state_q.refused;
         end else if (wb_adr_i == `SPRS_OFS_TIME) begin
            state_d.dat[5:0]  = state_q.mm;
            state_d.dat[14:8] = state_q.hh;
         end else if (wb_adr_i == `SPRS_OFS_STARTSP) begin
            state_d.dat[15:0] = state_q.startSp;
         end
      end

      if (writeCtrl) begin
         if (state_q.st == SPRS_RUN || state_d.st == SPRS_RUN) begin
            state_d.refused = 1'b1;
         end else begin
            state_d.refused = 1'b0;
            if (wb_sel_i[0]) begin
               if (wb_dat_i[3:0] >= `SPRS_SEG_FIRST && wb_dat_i[3:0] <= `SPRS_SEG_LAST) begin
                  state_d.cfgEndSeg = wb_dat_i[3:0];
               end
            end
            if (wb_sel_i[1] && wb_dat_i[14:8] <= `SPRS_CYC_MAX) begin
               state_d.cfgRecyc = wb_dat_i[14:8];
            end
            if (wb_sel_i[2]) begin
               state_d.cfgEndHold = wb_dat_i[`SPRS_CTRL_ENDHOLD_BIT];
               state_d.cfgLastSp  = wb_dat_i[`SPRS_CTRL_LASTSP_BIT];
               state_d.cfgDiFunc  = wb_dat_i[`SPRS_CTRL_DIFUNC_LSB +: 3];
            end
         end
      end
   end

   // ****************************************************************
   // Register stage
   // ****************************************************************
   // Synchronous reset; power-up lands in hold at the first segment.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q            <= '0;
         state_q.st         <= SPRS_HOLD;
         state_q.savedSt    <= SPRS_HOLD;
         state_q.fresh      <= 1'b1;
         state_q.loadPend   <= 1'b1;
         state_q.powerUp    <= 1'b1;
         state_q.seg        <= `SPRS_SEG_FIRST;
         state_q.blinkOn    <= 1'b1;
         state_q.keyPrev    <= 1'b1;
         state_q.diPrev     <= 1'b1;
         state_q.cfgEndSeg  <= `SPRS_RST_ENDSEG;
         state_q.cfgRecyc   <= `SPRS_RST_CYCLES_LEFT_VIEW;
         state_q.cfgEndHold <= `SPRS_RST_ENDHOLD;
         state_q.cfgLastSp  <= `SPRS_RST_LASTSP;
         state_q.cfgDiFunc  <= `SPRS_RST_DIFUNC;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Indicators follow the registered state.
   assign runIndicator  = (state_q.st == SPRS_RUN);
   assign holdIndicator = (state_q.st == SPRS_HOLD) & state_q.blinkOn;
   assign spFreeze      = (state_q.st != SPRS_RUN);
   assign paramEditOk   = (state_q.st != SPRS_RUN);
   assign segNum        = state_q.seg;
   assign segIsRamp     = state_q.seg[0];
   assign timeHours     = state_q.hh;
   assign timeMins      = state_q.mm;
   assign cyclesLeft    = state_q.cyc;
   assign manualMode    = state_q.manual;
   assign failsafeOut   = state_q.manual;
   assign ctrlMode      = state_q.ctrlMode;
   // Nonvolatile record of an active program for power-loss recovery.
   assign progActive    = ~state_q.fresh & ~state_q.done & (state_q.st != SPRS_ENDED);
   assign startSpOut    = state_q.startSp;
   assign spRestore     = state_q.spOut;
   assign spRestoreLoad = state_q.spLoad;
   assign wb_dat_o      = state_q.dat;
   assign wb_ack_o      = state_q.ack;

endmodule

// ==== verif/sprs_sequencer_assertions.sv ====
// Port checker for the setpoint program run/hold sequencer.
`timescale 1ns/1ps
module sprs_seq_checker (
   // Clock, reset and bus handshake.
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // Keypad and power-up record.
   input wire logic        runHoldKey,
   input wire logic        nvProgActive,
   input wire logic [15:0] nvStartSp,
   input wire logic [1:0]  powerOnModeIn,
   // Watched outputs.
   input wire logic        runIndicator,
   input wire logic        spFreeze,
   input wire logic        paramEditOk,
   input wire logic [3:0]  segNum,
   input wire logic [6:0]  cyclesLeft,
   input wire logic        manualMode,
   input wire logic [1:0]  ctrlMode,
   input wire logic [15:0] spRestore,
   input wire logic        spRestoreLoad
);
   // One domain, so one clocking and one reset for every property.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ********************
   // Assertions
   // ********************
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack stood longer than one cycle");
   ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in one cycle");
   edit_lock_a: assert property (paramEditOk == !runIndicator)
      else $error("edit permission disagrees with run state");
   hold_freeze_a: assert property (spFreeze == !runIndicator)
      else $error("setpoint freeze disagrees with run state");
   // The past reset term keeps the reset-high key history from faking an edge.
   key_starts_a: assert property (
      $rose(runHoldKey) && $past(rst_n) && !runIndicator |=> runIndicator)
      else $error("key press did not start the program");
   key_holds_a: assert property (
      $rose(runHoldKey) && $past(rst_n) && runIndicator |=> !runIndicator)
      else $error("key press did not hold the program");
   seg_range_a: assert property (segNum >= 4'h1 && segNum <= 4'hC)
      else $error("segment number out of range");
   cycle_range_a: assert property (cyclesLeft <= 7'h63)
      else $error("cycle count out of range");
   restore_start_a: assert property ($rose(rst_n) && nvProgActive |=>
      spRestoreLoad && spRestore == $past(nvStartSp) && !runIndicator)
      else $error("power-loss restore missing after power-up");
   power_mode_a: assert property ($rose(rst_n) |=> ctrlMode == $past(powerOnModeIn))
      else $error("power-up control mode not taken");
   manual_at_end_a: assert property ($rose(manualMode) |-> !runIndicator)
      else $error("manual mode entered while running");
   // Main scenarios reached.
   cover property ($rose(runIndicator));
   cover property ($fell(runIndicator));
   cover property ($rose(manualMode));
endmodule

bind sprs_sequencer sprs_seq_checker chk (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .runHoldKey(runHoldKey),
   .nvProgActive(nvProgActive), .nvStartSp(nvStartSp), .powerOnModeIn(powerOnModeIn),
   .runIndicator(runIndicator), .spFreeze(spFreeze), .paramEditOk(paramEditOk),
   .segNum(segNum), .cyclesLeft(cyclesLeft), .manualMode(manualMode), .ctrlMode(ctrlMode),
   .spRestore(spRestore), .spRestoreLoad(spRestoreLoad));

// ==== verif/sprs_keypad_model.sv ====
// Operator keypad and remote dry-contact model for the sequencer bench.
`timescale 1ns/1ps
module sprs_keypad_model (
   // Clock.
   input  wire logic mclk,
   // Switch levels toward the sequencer.
   output logic      runHoldKey,
   output logic      contactClosed
);
   // ********************
   // Switch actions
   // ********************
   // Both switches rest open so reset sees no edge.
   initial begin
      runHoldKey = 1'b0;
      contactClosed = 1'b0;
   end
   // one clean press
   // One cycle high is one press; the gap lets outputs settle.
   task automatic press();
      @(posedge mclk);
      runHoldKey <= 1'b1;
      @(posedge mclk);
      runHoldKey <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic contact(input logic v);
      @(posedge mclk);
      contactClosed <= v;
      repeat (3) @(posedge mclk);
   endtask
endmodule

// ==== verif/sprs_sequencer_tb.sv ====
// Self-checking bench for the setpoint program run/hold sequencer.
`timescale 1ns/1ps
`include "sprs_consts.svh"
`define CHK(n, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("wrong value %s exp %0h got %0h", n, e, g); \
   end \
end
module sprs_sequencer_tb;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic [5:0]  segM = 6'h08;
   logic [15:0] spIn = 16'h0;
   logic [15:0] nvSp = 16'h0;
   logic [1:0]  pm = 2'h0;
   logic [6:0]  segH;
   logic [3:0]  sel = 4'hF;
   logic        nvAct;
   logic        editOk, rampOut, failsafeOut, progActive, spLoadOut;
   logic [6:0]  timeHours, cyclesLeft;
   logic [5:0]  timeMins;
   logic [15:0] startSpOut;
   logic        ack, key, con, runIndicator, holdIndicator, spFreeze, manualMode;
   logic [3:0]  segNum;
   logic [1:0]  ctrlMode;
   logic [15:0] spRestore;
   int          seed, r, w, mSt, mSeg, mCyc, n1;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;

   sprs_sequencer #(.MINUTE_CYCLES(20), .BLINK_CYCLES(4)) DUT (.mclk(mclk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .runHoldKey(key),
      .contactClosed(con), .segHoursIn(segH), .segMinsIn(segM), .setpointIn(spIn),
      .nvProgActive(nvAct), .nvStartSp(nvSp), .powerOnModeIn(pm),
      .runIndicator(runIndicator), .holdIndicator(holdIndicator), .spFreeze(spFreeze),
      .paramEditOk(editOk), .segNum(segNum), .segIsRamp(rampOut), .timeHours(timeHours),
      .timeMins(timeMins), .cyclesLeft(cyclesLeft), .manualMode(manualMode),
      .failsafeOut(failsafeOut), .ctrlMode(ctrlMode), .progActive(progActive),
      .startSpOut(startSpOut), .spRestore(spRestore), .spRestoreLoad(spLoadOut));
   sprs_keypad_model kp (.mclk(mclk), .runHoldKey(key), .contactClosed(con));

   // ********************
   // Clock, timeout and helpers
   // ********************
   always #2 mclk = ~mclk;
   // A hung handshake or wait still ends in the one closing report.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Classic cycle: hold the request until ack is sampled, then release.
   task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      wdat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Control word: last segment 2, end in hold, manual at end.
   function automatic logic [31:0] mk(input logic [2:0] di);
      return {9'h0, di, 2'h0, 1'b0, 1'b1, 1'b0, 7'(r), 4'h0, 4'h2};
   endfunction
   task automatic chkSt();
      wb(1'b0, `SPRS_OFS_STATUS, 32'h0);
      `CHK("state", 2'(mSt), q[1:0])
      `CHK("runInd", mSt == 1, runIndicator)
      `CHK("freeze", mSt != 1, spFreeze)
      `CHK("cycles", 7'(mCyc), q[22:16])
      `CHK("editOk", mSt != 1, editOk)
      `CHK("cycOut", 7'(mCyc), cyclesLeft)
      if (mSeg > 0) begin
         `CHK("seg", 4'(mSeg), q[7:4])
         `CHK("ramp", 1'(mSeg % 2), q[8])
         `CHK("rampOut", 1'(mSeg % 2), rampOut)
      end
   endtask
   task automatic waitSeg2();
      w = 0;
      while (segNum !== 4'h2 && w < 600) begin
         @(posedge mclk);
         w++;
      end
      mSeg = 2;
   endtask
   // Waits for the program to leave the running state.
   task automatic waitStop();
      w = 0;
      while (runIndicator === 1'b1 && w < 6000) begin
         @(posedge mclk);
         w++;
      end
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin
      seed = 75138;
      r = $unsigned($random(seed)) % 3;
      segM = 6'(8 + $unsigned($random(seed)) % 4);
      nvSp = 16'($random(seed));
      spIn = 16'($random(seed));
      pm = 2'($random(seed));
      segH = 7'($random(seed));
      nvAct = 1'($random(seed));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      // The restore strobe stands only in the first cycle after release.
      @(posedge mclk);
      #1;
      `CHK("spLoad", nvAct, spLoadOut)
      @(posedge mclk);
      `CHK("ctrlMode", pm, ctrlMode)
      `CHK("spRestore", nvAct ? nvSp : 16'h0, spRestore)
      `CHK("hours", segH, timeHours)
      `CHK("mins", segM, timeMins)
      // Hours are zeroed so that segments stay short once running.
      segH <= 7'h00;
      wb(1'b0, `SPRS_OFS_STARTSP, 32'h0);
      `CHK("startSp", nvAct ? nvSp : 16'h0, q[15:0])
      wb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 32'h0, q)
      mSt = 0;
      mSeg = 1;
      mCyc = 0;
      chkSt();
      wb(1'b1, `SPRS_OFS_CTRL, mk(`SPRS_DI_HOLD));
      wb(1'b0, `SPRS_OFS_CTRL, 32'h0);
      `CHK("ctrl", mk(`SPRS_DI_HOLD), q)
      kp.press();
      mSt = 1;
      mCyc = r;
      chkSt();
      `CHK("startSpOut", spIn, startSpOut)
      `CHK("active", 1'b1, progActive)
      // A write while running is answered and flagged refused but must change no control field.
      wb(1'b1, `SPRS_OFS_CTRL, mk(`SPRS_DI_BEGIN));
      wb(1'b0, `SPRS_OFS_CTRL, 32'h0);
      `CHK("ctrlKept", mk(`SPRS_DI_HOLD), q)
      kp.contact(1'b1);
      mSt = 0;
      chkSt();
      `CHK("refused", 1'b1, q[24])
      n1 = 0;
      repeat (12) begin
         @(posedge mclk);
         n1 += int'(holdIndicator === 1'b1);
      end
      `CHK("blink", 1'b1, n1 > 0 && n1 < 12)
      kp.contact(1'b0);
      mSt = 1;
      chkSt();
      kp.contact(1'b1);
      kp.press();
      chkSt();
      kp.contact(1'b0);
      chkSt();
      kp.press();
      mSt = 0;
      chkSt();
      wb(1'b1, `SPRS_OFS_CTRL, mk(`SPRS_DI_BEGIN));
      chkSt();
      `CHK("refusedClr", 1'b0, q[24])
      kp.press();
      mSt = 1;
      waitSeg2();
      chkSt();
      kp.contact(1'b1);
      mSt = 0;
      mSeg = 1;
      chkSt();
      kp.contact(1'b0);
      chkSt();
      wb(1'b1, `SPRS_OFS_CTRL, mk(`SPRS_DI_RUN));
      kp.contact(1'b1);
      mSt = 1;
      chkSt();
      kp.contact(1'b0);
      mSt = 0;
      chkSt();
      wb(1'b1, `SPRS_OFS_CTRL, mk(`SPRS_DI_RESTART));
      kp.press();
      mSt = 1;
      waitSeg2();
      kp.contact(1'b1);
      mSeg = 1;
      chkSt();
      kp.contact(1'b0);
      chkSt();
      // Let every recycle run out; the program must stop in hold, manual.
      waitStop();
      mSt = 0;
      mSeg = 0;
      mCyc = 0;
      chkSt();
      `CHK("manualBit", 1'b1, q[9])
      `CHK("manualMode", 1'b1, manualMode)
      `CHK("failsafe", 1'b1, failsafeOut)
      // Second ending: one segment, no recycle, programming disabled at last setpoint.
      wb(1'b1, `SPRS_OFS_CTRL, 32'h0002_0001);
      kp.press();
      waitStop();
      mSt = 2;
      chkSt();
      `CHK("lastSp", 1'b0, failsafeOut)
      `CHK("idle", 1'b0, progActive)
      wrap_up();
   end
endmodule
